// [test/cwd_watchdog_tb.sv]
// Self-checking bench for the crystal clocked watchdog.
// Assumes the bench drives every port itself; the crystal is a fast toggle that the bench can stop.
`timescale 1ns/1ps
module cwd_watchdog_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin = 1'b1;
  logic xtal = 1'b0;
  logic lock_bit = 1'b1;
  logic retire = 1'b0;
  cwd_pkg::cwd_sfr_req_t sfr = '0;
  cwd_pkg::cwd_bit_req_t bq = '0;
  logic [7:0] rdata;
  logic sys_o;
  logic dl_o;
  logic irq_o;
  logic xrun = 1'b0;
  logic [1:0] xdiv = 2'h0;
  int n_mismatch = 0;
  int check_count = 0;
  int edges = 0;
  int cycles = 0;

  cwd_watchdog #(.CNT_W(16)) dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_pin_rst(pin),
    .i_crystal_in_pin(xtal), .i_flash_wd_lock_bit(lock_bit), .i_instr_retire(retire),
    .i_sfr(sfr), .i_bit(bq), .o_sfr_rdata(rdata), .o_wd_sys_rst(sys_o),
    .o_wd_dl_rst(dl_o), .o_wd_irq(irq_o));

  initial forever #50 clk = ~clk;

  // The crystal stands still while registers are set up, so edge counts are exact.
  always @(posedge clk)
  begin
    xdiv <= xdiv + 2'h1;
    if (xrun)
      xtal <= xdiv[1];
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  always @(posedge xtal) edges++;

  task automatic report_and_stop();
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset(input logic from_pin);
    @(posedge clk);
    rst <= 1'b1;
    pin <= from_pin;
    step(6);
    rst <= 1'b0;
    pin <= 1'b0;
    step(3);
  endtask

  // Unlock instruction followed by its retire; the caller's write is the next instruction.
  task automatic unlock();
    @(posedge clk);
    bq <= {1'b1, 8'hC0, 1'b1};
    @(posedge clk);
    bq <= '0;
    retire <= 1'b1;
    @(posedge clk);
    retire <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] v);
    unlock();
    @(posedge clk);
    sfr <= {1'b1, 8'hC0, v};
    retire <= 1'b1;
    @(posedge clk);
    sfr <= '0;
    retire <= 1'b0;
    step(2);
  endtask

  task automatic wait_evt(output logic s, output logic i);
    edges = 0;
    xrun <= 1'b1;
    repeat (3000)
    begin
      @(posedge clk);
      #1;
      if (sys_o === 1'b1 || irq_o === 1'b1)
        break;
    end
    xrun <= 1'b0;
    s = sys_o;
    i = irq_o;
    chk("edges to expiry", 16'h0200, edges[15:0]);
    @(posedge clk);
    #1;
    chk("pulse width", 16'h0000, {14'h0, sys_o, irq_o});
  endtask

  task automatic no_evt();
    int hits;
    hits = 0;
    xrun <= 1'b1;
    repeat (2600)
    begin
      @(posedge clk);
      #1;
      if (sys_o === 1'b1 || irq_o === 1'b1 || dl_o === 1'b1)
        hits++;
    end
    xrun <= 1'b0;
    chk("quiet outputs", 16'h0000, hits[15:0]);
  endtask

  task automatic t_access();
    chk("reset image", 16'h0072, {8'h0, rdata});
    @(posedge clk);
    sfr <= {1'b1, 8'hC0, 8'h00};
    retire <= 1'b1;
    @(posedge clk);
    sfr <= '0;
    retire <= 1'b0;
    step(2);
    chk("write without unlock", 16'h0072, {8'h0, rdata});
    unlock();
    step(1);
    chk("armed image", 16'h0073, {8'h0, rdata});
    retire <= 1'b1;
    @(posedge clk);
    retire <= 1'b0;
    sfr <= {1'b1, 8'hC0, 8'h00};
    @(posedge clk);
    sfr <= '0;
    step(2);
    chk("late write", 16'h0072, {8'h0, rdata});
    unlock();
    @(posedge clk);
    bq <= {1'b1, 8'hC1, 1'b0};
    retire <= 1'b1;
    @(posedge clk);
    bq <= '0;
    retire <= 1'b0;
    step(2);
    chk("disabled image", 16'h0070, {8'h0, rdata});
    no_evt();
  endtask

  task automatic t_reset_mode();
    logic s;
    logic i;
    wr(8'h02);
    @(posedge clk);
    xrun <= 1'b1;
    step(1200);
    xrun <= 1'b0;
    wr(8'h02);
    wait_evt(s, i);
    chk("reset response", 16'h0002, {14'h0, s, i});
    chk("status set", 16'h0006, {8'h0, rdata});
    do_reset(1'b0);
    chk("status kept", 16'h0076, {8'h0, rdata});
    do_reset(1'b1);
    chk("status cleared", 16'h0072, {8'h0, rdata});
  endtask

  task automatic t_irq_mode();
    logic s;
    logic i;
    wr(8'h0A);
    wait_evt(s, i);
    chk("first interrupt", 16'h0001, {14'h0, s, i});
    chk("irq status", 16'h000E, {8'h0, rdata});
    wait_evt(s, i);
    chk("periodic interrupt", 16'h0001, {14'h0, s, i});
  endtask

  task automatic t_codes();
    wr(8'h82);
    step(3);
    chk("immediate reset", 16'h0002, {14'h0, sys_o, dl_o});
    chk("immediate status", 16'h0004, {8'h0, rdata & 8'h04});
    wr(8'h92);
    step(3);
    chk("download reset", 16'h0001, {14'h0, sys_o, dl_o});
    wr(8'hA2);
    step(3);
    no_evt();
    do_reset(1'b1);
  endtask

  task automatic t_lock();
    @(posedge clk);
    lock_bit <= 1'b0;
    wr(8'h08);
    chk("locked image", 16'h0002, {8'h0, rdata});
    wr(8'h58);
    chk("locked select", 16'h0052, {8'h0, rdata});
    @(posedge clk);
    lock_bit <= 1'b1;
    step(3);
    chk("stored bits", 16'h0058, {8'h0, rdata});
  endtask

  initial
  begin
    step(6);
    rst <= 1'b0;
    pin <= 1'b0;
    step(3);
    t_access();
    t_reset_mode();
    t_irq_mode();
    t_codes();
    t_lock();
    report_and_stop();
  end
endmodule // cwd_watchdog_tb

// [verilog/cwd_consts.svh]
// Constants of the crystal clocked watchdog: register address, field positions, reset values and timeout scaling.
// Assumes it is included by bare name from the design modules.
// Overview of operation
// [R01] After reset the watchdog is enabled, its timeout select is 0111 (two seconds) and a timeout resets the system.
// [R02] Clearing the enable bit (bit 1) of the control register stops the watchdog.
// [R03] The counter advances on edges of the 32.768 kHz crystal, not on the processor clock.
// [R04] A 16-bit counter is used and the four-bit select field picks which upper counter bit marks expiry.
// [R05] Select codes 0000 to 0111 give timeouts doubling from 15.6 ms to 2 s, with 0110 giving one second.
// [R06] Code 1000 resets at once, code 1001 causes a serial-download reset at once, codes 1010 to 1111 are invalid.
// [R07] On expiry a clear response bit (bit 3) gives a system reset and a set one gives an interrupt instead.
// [R08] Status bit 2 is set on a timeout, cleared only by writing 0 or by a pin reset, and survives a watchdog reset.
// [R09] Every accepted write that sets the enable bit enables the watchdog and clears its counter.
// [R10] Every write to the control register must follow the unlock step, and other writes are ignored.
// [R11] The unlock is setting bit 0, and only a write in the very next instruction is accepted.
// [R12] With the flash lock bit at zero the response bit reads 0 and the enable bit reads 1 whatever is written.
// [R13] The flash lock bit is changed only through the flash protection procedure, never by an ordinary write.
// [R14] While the flash lock is active software may still change the timeout select field.
// [R15] The watchdog interrupt is always high priority and is not masked by the global interrupt enable.
// [R16] In interrupt mode the counter restarts from zero after each timeout so interrupts repeat periodically.
`ifndef CWD_CONSTS_SVH
`define CWD_CONSTS_SVH

`define CWD_CTRL_ADDR 8'hC0
`define CWD_BIT_UNLOCK 0
`define CWD_BIT_ENABLE 1
`define CWD_BIT_STATUS 2
`define CWD_BIT_RESP 3
`define CWD_SEL_LSB 4
`define CWD_SEL_MSB 7

`define CWD_RST_SEL 4'h7
`define CWD_RST_ENABLE 1'h1
`define CWD_RST_RESP 1'h0

`define CWD_SEL_IMM_RST 4'h8
`define CWD_SEL_IMM_DL 4'h9
`define CWD_SEL_LAST_TIMED 4'h7

// Select code 0000 expires after 2^9 crystal edges (15.6 ms at 32.768 kHz).
`define CWD_XTAL_HZ 32768
`define CWD_BASE_LOG2 9
`define CWD_CNT_W 16

`endif

// [verilog/cwd_pkg.sv]
// Types shared by the crystal clocked watchdog modules.
// Assumes the special function register bus of the processor core as its only access path.
package cwd_pkg;

  // Byte access to a special function register; data are valid with the strobe.
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cwd_sfr_req_t;

  // Single bit write of a bit addressable register (set or clear of one bit).
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic val;
  } cwd_bit_req_t;

  typedef enum logic [1:0] {
    CWD_CLS_TIMED,
    CWD_CLS_IMM_RST,
    CWD_CLS_IMM_DL,
    CWD_CLS_INVALID
  } cwd_sel_class_t;

endpackage

// [verilog/cwd_sel_decode.sv]
// Decoder of the timeout select field into a code class and a counter compare mask.
// Assumes a counter of at least CWD_BASE_LOG2 + 7 bits.
`timescale 1ns/1ps
`include "cwd_consts.svh"

module cwd_sel_decode
#(
  parameter int CNT_W = `CWD_CNT_W
)
(
  input wire logic [3:0] i_sel,
  output cwd_pkg::cwd_sel_class_t o_class,
  output logic [CNT_W-1:0] o_mask
);

  // Code n expires when the low 9+n counter bits are all ones on a crystal edge.
  function automatic logic [CNT_W-1:0] sel_mask(input logic [3:0] sel);
    logic [CNT_W:0] one;
    one = {{CNT_W{1'h0}}, 1'h1};
    sel_mask = CNT_W'((one << (`CWD_BASE_LOG2 + 32'(sel[2:0]))) - one); // [R04] [R05]
  endfunction

  assign o_mask = sel_mask(i_sel);
  assign o_class = (i_sel <= `CWD_SEL_LAST_TIMED) ? cwd_pkg::CWD_CLS_TIMED :
                   (i_sel == `CWD_SEL_IMM_RST) ? cwd_pkg::CWD_CLS_IMM_RST :
                   (i_sel == `CWD_SEL_IMM_DL) ? cwd_pkg::CWD_CLS_IMM_DL :
                   cwd_pkg::CWD_CLS_INVALID; // [R06]

endmodule // cwd_sel_decode

// [verilog/cwd_watchdog.sv]
// Watchdog timer with its control register on the special function register bus.
// Assumes i_instr_retire pulses once at the end of every instruction, after that instruction's writes.
// Assumes the core applies i_sys_rst for every reset, and i_pin_rst in addition only for a reset from the pin.
`timescale 1ns/1ps
`include "cwd_consts.svh"

module cwd_watchdog
#(
  parameter int CNT_W = `CWD_CNT_W
)
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin_rst,
  input wire logic i_crystal_in_pin,
  input wire logic i_flash_wd_lock_bit,
  input wire logic i_instr_retire,
  input wire cwd_pkg::cwd_sfr_req_t i_sfr,
  input wire cwd_pkg::cwd_bit_req_t i_bit,
  output logic [7:0] o_sfr_rdata,
  output logic o_wd_sys_rst,
  output logic o_wd_dl_rst,
  output logic o_wd_irq
);

  logic [3:0] sel_q;
  logic [3:0] sel_d;
  logic enable_q;
  logic enable_d;
  logic resp_q;
  logic resp_d;
  logic status_q;
  logic status_d;
  logic armed_q;
  logic armed_d;
  logic fresh_q;
  logic fresh_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic sys_rst_q;
  logic dl_rst_q;
  logic irq_q;
  logic [7:0] rdata_q;

  wire logic tick;
  wire cwd_pkg::cwd_sel_class_t sel_class;
  wire logic [CNT_W-1:0] sel_mask;

  cwd_xtal_edge u_edge
  (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_xtal(i_crystal_in_pin),
    .o_tick(tick)
  );

  cwd_sel_decode #(.CNT_W(CNT_W)) u_dec
  (
    .i_sel(sel_q),
    .o_class(sel_class),
    .o_mask(sel_mask)
  );

  // Register image as software sees it; a zero flash lock bit overrides enable and response.
  wire logic locked = ~i_flash_wd_lock_bit; // [R12]
  wire logic enable_eff = locked | enable_q; // [R12]
  wire logic resp_eff = ~locked & resp_q; // [R12]
  wire logic [7:0] cur_val = {sel_q, resp_eff, status_q, enable_eff, armed_q};

  // Byte writes and bit writes are merged into one candidate value for the register.
  wire logic byte_hit = i_sfr.wr & (i_sfr.addr == `CWD_CTRL_ADDR);
  wire logic bit_hit = i_bit.wr & (i_bit.addr[7:3] == 5'(`CWD_CTRL_ADDR >> 3));
  wire logic any_wr = byte_hit | bit_hit;
  wire logic [7:0] bit_mask = 8'h01 << i_bit.addr[2:0];
  wire logic [7:0] bit_val = i_bit.val ? (cur_val | bit_mask) : (cur_val & ~bit_mask);
  wire logic [7:0] wr_val = byte_hit ? i_sfr.wdata : bit_val;

  // A write that sets bit 0 only arms the unlock; the next instruction's write is the one taken.
  wire logic unlock_wr = any_wr & ~armed_q & wr_val[`CWD_BIT_UNLOCK]; // [R11]
  wire logic accept_wr = any_wr & armed_q; // [R10] [R11]
  wire logic kick = accept_wr & wr_val[`CWD_BIT_ENABLE]; // [R09]

  wire logic timed = sel_class == cwd_pkg::CWD_CLS_TIMED;
  wire logic expire = enable_eff & timed & tick & ((cnt_q & sel_mask) == sel_mask); // [R04] [R05]
  wire logic imm_rst = enable_eff & (sel_class == cwd_pkg::CWD_CLS_IMM_RST); // [R06]
  wire logic imm_dl = enable_eff & (sel_class == cwd_pkg::CWD_CLS_IMM_DL); // [R06]
  wire logic event_hit = expire | imm_rst | imm_dl;

  always_comb
  begin
    sel_d = accept_wr ? wr_val[`CWD_SEL_MSB:`CWD_SEL_LSB] : sel_q; // [R14]
    enable_d = accept_wr ? wr_val[`CWD_BIT_ENABLE] : enable_q; // [R02]
    resp_d = accept_wr ? wr_val[`CWD_BIT_RESP] : resp_q; // [R07]
    // A timeout in the same cycle as a clearing write keeps the flag set.
    status_d = status_q;
    if (accept_wr && !wr_val[`CWD_BIT_STATUS])
      status_d = 1'h0;
    if (event_hit)
      status_d = 1'h1; // [R08]
    if (i_pin_rst)
      status_d = 1'h0; // [R08]
    armed_d = armed_q;
    fresh_d = fresh_q;
    if (accept_wr)
    begin
      armed_d = 1'h0;
      fresh_d = 1'h0;
    end
    else if (unlock_wr)
    begin
      armed_d = 1'h1;
      fresh_d = 1'h1;
    end
    else if (i_instr_retire)
    begin
      // The retire of the unlocking instruction itself only ends its freshness.
      armed_d = fresh_q & armed_q; // [R11]
      fresh_d = 1'h0;
    end
  end

  always_comb
  begin
    cnt_d = cnt_q;
    if (!enable_eff || kick || expire)
      cnt_d = '0; // [R02] [R09] [R16]
    else if (tick && timed)
      cnt_d = cnt_q + CNT_W'(1); // [R03]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      sel_q <= `CWD_RST_SEL; // [R01]
      enable_q <= `CWD_RST_ENABLE; // [R01]
      resp_q <= `CWD_RST_RESP; // [R01]
      armed_q <= 1'h0;
      fresh_q <= 1'h0;
      cnt_q <= '0;
      sys_rst_q <= 1'h0;
      dl_rst_q <= 1'h0;
      irq_q <= 1'h0;
      rdata_q <= 8'h00;
    end
    else
    begin
      sel_q <= sel_d;
      enable_q <= enable_d;
      resp_q <= resp_d;
      armed_q <= armed_d;
      fresh_q <= fresh_d;
      cnt_q <= cnt_d;
      sys_rst_q <= (expire & ~resp_eff) | imm_rst; // [R07] [R06]
      dl_rst_q <= imm_dl; // [R06]
      irq_q <= expire & resp_eff; // [R07] [R15]
      rdata_q <= cur_val;
    end
  end

  // The status flag outlives a watchdog reset, so of the resets only the pin reset clears it.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_pin_rst)
      status_q <= 1'h0;
    else
      status_q <= status_d; // [R08]
  end

  // The interrupt leaves here unqualified; the core must route it past the global enable.
  assign o_wd_irq = irq_q; // [R15]
  assign o_wd_sys_rst = sys_rst_q;
  assign o_wd_dl_rst = dl_rst_q;
  assign o_sfr_rdata = rdata_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_unlock;
    unlock_wr ##1 !any_wr;
  endsequence

  sequence s_unlock_expired;
    s_unlock ##0 i_instr_retire ##1 !any_wr ##1 (i_instr_retire && !any_wr);
  endsequence

  sequence s_disable_write;
    accept_wr && !wr_val[`CWD_BIT_ENABLE] && !locked ##1 !locked && !accept_wr;
  endsequence

  a_reset_defaults: assert property (disable iff (1'b0)
    $fell(i_sys_rst) |-> sel_q == 4'h7 && enable_q && !resp_q) // [R01]
    else $error("Watchdog control did not come out of reset at its defaults.");

  a_disabled_idle: assert property (!enable_eff |=> cnt_q == '0 && !o_wd_irq && !o_wd_sys_rst) // [R02]
    else $error("Disabled watchdog kept counting or fired.");

  a_tick_advance: assert property (enable_eff && timed && !tick && !kick |=> cnt_q == $past(cnt_q)) // [R03]
    else $error("Counter moved without a crystal edge.");

  a_expiry_point: assert property (expire |-> (cnt_q & sel_mask) == sel_mask && tick) // [R04] [R05]
    else $error("Expiry taken away from the selected counter bit.");

  a_two_sec: assert property (enable_eff && sel_q == 4'h7 && tick && cnt_q == 16'hFFFF && !kick
    |=> (o_wd_sys_rst || o_wd_irq)) // [R05]
    else $error("Two second timeout missed at counter wrap.");

  a_immediate_rst: assert property (enable_eff && sel_q == 4'h8 |=> o_wd_sys_rst && !o_wd_dl_rst) // [R06]
    else $error("Immediate reset code did not reset.");

  a_invalid_quiet: assert property (sel_q >= 4'hA |=> !o_wd_sys_rst && !o_wd_dl_rst && !o_wd_irq) // [R06]
    else $error("Invalid select code produced an event.");

  a_resp_route: assert property (expire |=> (o_wd_irq == $past(resp_eff)) && (o_wd_sys_rst != $past(resp_eff))) // [R07]
    else $error("Timeout response went to the wrong output.");

  a_status_sticky: assert property (event_hit && !i_pin_rst |=> status_q) // [R08]
    else $error("Timeout did not set the status flag.");

  a_kick_clears: assert property (kick |=> cnt_q == '0 && enable_q) // [R09]
    else $error("Accepted enable write did not restart the counter.");

  a_locked_write: assert property (any_wr && !armed_q && !unlock_wr && !event_hit && !i_pin_rst
    |=> $stable(sel_q) && $stable(enable_q) && $stable(resp_q) && $stable(status_q)) // [R10]
    else $error("Write without unlock changed the control register.");

  a_window_closes: assert property (s_unlock_expired |=> !armed_q) // [R11]
    else $error("Unlock stayed open past the next instruction.");

  a_flash_lock: assert property (locked |-> o_sfr_rdata[3] == 1'b0 || $past(!locked)) // [R12]
    else $error("Flash lock did not force the response bit.");

  a_lock_keeps_sel: assert property (locked && accept_wr |=> sel_q == $past(wr_val[7:4])) // [R14]
    else $error("Timeout select write lost under flash lock.");

  a_irq_restart: assert property (expire && resp_eff && !kick |=> cnt_q == '0 ##1 !o_wd_irq) // [R16]
    else $error("Interrupt mode did not restart the period.");

  // Per-step checks of the unlock handshake, the status flag, the enable bit, the counter hold and the response outputs.
  // The pin reset arrives together with the system reset, so this one must not be disabled by it.
  a_pin_clears: assert property (disable iff (1'b0) i_pin_rst |=> !status_q) // [R08]
    else $error("Pin reset did not clear the status flag.");

  a_status_clear: assert property (accept_wr && !wr_val[`CWD_BIT_STATUS] && !event_hit |=> !status_q) // [R08]
    else $error("Writing zero did not clear the status flag.");

  a_unlock_arms: assert property (unlock_wr |=> armed_q) // [R11]
    else $error("Unlock write did not arm the register.");

  a_accept_disarms: assert property (accept_wr |=> !armed_q) // [R11]
    else $error("Accepted write left the unlock armed.");

  a_enable_off: assert property (s_disable_write |=> !o_sfr_rdata[1]) // [R02]
    else $error("Clearing the enable bit did not stop the watchdog.");

  a_dl_code: assert property (enable_eff && sel_q == 4'h9 |=> o_wd_dl_rst && !o_wd_sys_rst) // [R06]
    else $error("Serial download code did not raise the download reset.");

  a_untimed_hold: assert property (enable_eff && !timed && !kick |=> cnt_q == $past(cnt_q)) // [R06]
    else $error("Counter moved under an untimed select code.");

  a_sel0_expiry: assert property (enable_eff && sel_q == 4'h0 && tick && cnt_q[8:0] == 9'h1FF && !kick
    |=> (o_wd_sys_rst || o_wd_irq)) // [R05]
    else $error("Shortest timeout missed at its counter bit.");

  a_no_early: assert property (enable_eff && timed && tick && (cnt_q & sel_mask) != sel_mask && !kick
    |=> !o_wd_sys_rst && !o_wd_irq) // [R04]
    else $error("Timeout fired before the selected counter bit.");

  a_irq_unmasked: assert property (expire && resp_eff |=> o_wd_irq) // [R15]
    else $error("Interrupt response did not raise the interrupt.");

  a_irq_pulse: assert property (o_wd_irq |=> !o_wd_irq) // [R16]
    else $error("Interrupt stayed high longer than one cycle.");

  a_irq_timed: assert property (o_wd_irq |-> $past(timed)) // [R07]
    else $error("Interrupt raised by an untimed select code.");

  a_lock_enable: assert property (locked |=> o_sfr_rdata[1]) // [R12]
    else $error("Flash lock did not force the enable bit.");

endmodule // cwd_watchdog

// [verilog/cwd_xtal_edge.sv]
// Rising edge detector for the crystal input, giving one reference clock pulse per crystal period.
// Assumes the crystal level is synchronous to the reference clock and far slower than it.
`timescale 1ns/1ps
`include "cwd_consts.svh"

module cwd_xtal_edge
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_xtal,
  output logic o_tick
);

  logic last_q;
  logic valid_q;

  // The pin may already be high when reset ends, so the first cycle after reset reports no edge.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      last_q <= 1'h0;
      valid_q <= 1'h0;
    end
    else
    begin
      last_q <= i_xtal;
      valid_q <= 1'h1;
    end
  end

  assign o_tick = i_xtal & ~last_q & valid_q; // [R03]

endmodule // cwd_xtal_edge
